// [hw/vwd_top.sv]
// Purpose: Slave and master address windows with timeouts
// Assumes: Configuration held steady by software while in use
// Notes:   Decode is combinational; addresses registered
`timescale 1ns/10ps
module vwd_top
   import vwd_pkg::*;
#(
   parameter int NSLV = 2,    // Slave windows
   parameter int NMST = 4     // Master windows
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // Slave window configuration
   input  wire logic [NSLV-1:0]   slv_en,
   input  wire logic [31:0]       slv_start [NSLV],
   input  wire logic [31:0]       slv_end   [NSLV],
   input  wire logic [31:0]       slv_xlat  [NSLV],
   input  wire logic [31:0]       slv_mask  [NSLV],
   input  wire logic [15:0]       slv_ctl   [NSLV],
   // Incoming bus access
   input  wire logic              vin_valid,
   input  wire logic [31:0]       vin_addr,
   input  wire logic [15:0]       vin_kind,    // One-hot access kind
   output logic                   vin_hit,
   output logic [NSLV-1:0]        vin_sel,
   output logic [31:0]            vin_laddr,
   // Master window configuration
   input  wire logic [NMST-1:0]   mst_en,
   input  wire logic [31:0]       mst_start [NMST],
   input  wire logic [31:0]       mst_end   [NMST],
   input  wire logic [31:0]       mst_xlat,
   input  wire logic [31:0]       mst_mask,
   input  wire logic [7:0]        mst_ctl   [NMST],
   input  wire logic              sio_en,
   input  wire logic [7:0]        sio_ctl,
   input  wire logic              fpg_en,
   input  wire logic [7:0]        fpg_ctl,
   input  wire logic [7:0]        group_select_value,
   input  wire logic [7:0]        board_select_value,
   // Local request
   input  wire logic              lb_valid,
   input  wire logic [31:0]       lb_addr,
   input  wire logic              lb_ack,      // Local cycle answered
   input  wire logic              bus_grant,   // Bus obtained
   input  wire logic              sys_ctl,     // Acting as system controller
   input  wire logic              bus_busy,    // Bus cycle in progress
   // Outgoing bus cycle
   output logic                   vout_start,
   output logic [31:0]            vout_addr,
   output logic [7:0]             vout_ctl,
   output logic                   vout_a16,
   output logic                   vout_a24,
   output logic                   ctl_block_hit, // Control block addressed
   // Timeouts
   input  wire logic [1:0]        bus_to_code,
   input  wire logic [1:0]        loc_to_code,
   input  wire logic [1:0]        acc_to_code,
   output logic                   bus_timeout,
   output logic                   loc_timeout,
   output logic                   acc_timeout
);
   // ****************************************
   // Slave windows
   // ****************************************
   logic [NSLV-1:0] s_match;   // Per window claim
   logic [31:0]     s_addr [NSLV];
   genvar g;
   generate
      for (g = 0; g < NSLV; g++) begin : g_slv
         // Enable, range and permitted kind all needed
         assign s_match[g] = slv_en[g] && vin_valid            // see R14
            && vin_addr >= slv_start[g] && vin_addr <= slv_end[g] // see R1
            && |(vin_kind & slv_ctl[g]);                       // see R4
         // Masked bits come from the translation base
         assign s_addr[g] = (slv_xlat[g] & slv_mask[g])        // see R2
                          | (vin_addr & ~slv_mask[g]);         // see R3
      end
   endgenerate
   // Lowest window wins on overlap
   logic [31:0] next_laddr;
   always_comb begin
      next_laddr = vin_laddr;
      for (int i = NSLV - 1; i >= 0; i--) begin
         if (s_match[i]) next_laddr = s_addr[i];
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vin_laddr <= 32'h0000_0000;
         vin_sel   <= '0;
         vin_hit   <= 1'b0;
      end else begin
         vin_laddr <= next_laddr;
         vin_sel   <= s_match;
         vin_hit   <= |s_match;
      end
   end
   // ****************************************
   // Master windows
   // ****************************************
   logic [NMST-1:0] m_match;
   generate
      for (g = 0; g < NMST; g++) begin : g_mst
         assign m_match[g] = mst_en[g] && lb_valid             // see R5
            && lb_addr >= mst_start[g] && lb_addr <= mst_end[g];
      end
   endgenerate
   logic sio_match;            // Short I/O window
   logic fpg_match;            // Top page window
   logic gc_match;             // Control block in short I/O
   assign sio_match = sio_en && lb_valid && lb_addr[31:16] == SIO_BASE; // see R8
   assign fpg_match = fpg_en && lb_valid && lb_addr[31:24] == FPG_BASE
                    && !(lb_addr[31:16] == SIO_BASE);                  // see R9
   assign gc_match  = sio_match && lb_addr[15:8] == group_select_value
                    && lb_addr[7:0] == board_select_value;             // see R10
   logic        next_start;
   logic [31:0] next_addr;
   logic [7:0]  next_ctl;
   logic        next_a16;
   logic        next_a24;
   // Short I/O first, then top page, then lowest master window
   always_comb begin
      next_start = 1'b0;                                 // see R15
      next_addr  = vout_addr;
      next_ctl   = vout_ctl;
      next_a16   = 1'b0;
      next_a24   = 1'b0;
      if (sio_match) begin
         next_start = 1'b1;
         next_addr  = {16'h0000, lb_addr[15:0]};
         next_ctl   = sio_ctl;
         next_a16   = 1'b1;
      end else if (fpg_match) begin
         next_start = 1'b1;
         next_addr  = {8'h00, lb_addr[23:0]};
         next_ctl   = fpg_ctl;
         next_a24   = 1'b1;
      end else begin
         for (int i = NMST - 1; i >= 0; i--) begin
            if (m_match[i]) begin
               next_start = 1'b1;
               next_ctl   = mst_ctl[i];                   // see R7
               if (i == NMST - 1)
                  next_addr = (mst_xlat & mst_mask)      // see R6
                            | (lb_addr & ~mst_mask);
               else
                  next_addr = lb_addr;
            end
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         vout_start <= 1'b0;
         vout_addr  <= 32'h0000_0000;
         vout_ctl   <= 8'h00;
         vout_a16   <= 1'b0;
         vout_a24   <= 1'b0;
         ctl_block_hit <= 1'b0;
      end else begin
         vout_start <= next_start;
         vout_addr  <= next_addr;
         vout_ctl   <= next_ctl;
         vout_a16   <= next_a16;
         vout_a24   <= next_a24;
         ctl_block_hit <= gc_match;
      end
   end
   // ****************************************
   // Timeouts
   // ****************************************
   // One microsecond tick; slower limits are counted in ticks
   logic [TICK_W-1:0] div;
   logic [TICK_W-1:0] next_div;
   logic              tick;
   assign tick = (div == TICK_W'(TICK_CYC - 1));
   always_comb next_div = tick ? '0 : div + 1'b1;
   always_ff @(posedge clk) begin
      if (!nrst) div <= '0;
      else       div <= next_div;
   end
   // Code n scales the figure for the documented code by powers of two (limitation:
   // only the documented codes are exact)
   logic [TO_W-1:0] bus_lim, loc_lim, acc_lim;
   assign bus_lim = TO_W'(BUS_TO_US1) << bus_to_code >> 1;      // see R11
   assign loc_lim = TO_W'(LOC_TO_US2) << loc_to_code >> 2;      // see R12
   // Access wait counted in 1 ms units of 1000 ticks would need a
   // second divider; counted directly in microseconds instead
   assign acc_lim = TO_W'(ACC_TO_MS2 * 1000) >> (2'd2 - acc_to_code); // see R13
   vwd_timer u_bus (.clk(clk), .nrst(nrst), .tick(tick),
      .run(sys_ctl && bus_busy), .limit(bus_lim), .expired(bus_timeout));
   vwd_timer u_loc (.clk(clk), .nrst(nrst), .tick(tick),
      .run(lb_valid && !lb_ack), .limit(loc_lim), .expired(loc_timeout));
   vwd_timer u_acc (.clk(clk), .nrst(nrst), .tick(tick),
      .run(lb_valid && !bus_grant), .limit(acc_lim), .expired(acc_timeout));
   // ****************************************
   // Checks
   // ****************************************
   // No claim from any window means no cycle in the next clock
   no_match_a: assert property (@(posedge clk) disable iff (!nrst) // see R15
      !(|m_match) && !sio_match && !fpg_match |=> !vout_start)
      else $error("bus cycle started without a window");
   slv_dis_a: assert property (@(posedge clk) disable iff (!nrst) // see R14
      !slv_en[0] |=> !vin_sel[0])
      else $error("disabled slave window claimed");
   slv_kind_a: assert property (@(posedge clk) disable iff (!nrst) // see R4
      !(|(vin_kind & slv_ctl[0])) |=> !vin_sel[0])
      else $error("slave accepted forbidden kind");
   // Watches the registered select, so a bad register path shows up
   slv_range_a: assert property (@(posedge clk) disable iff (!nrst) // see R1
      vin_sel[0] |-> $past(vin_addr) >= $past(slv_start[0])
                  && $past(vin_addr) <= $past(slv_end[0]))
      else $error("slave claim outside range");
   slv_xlat_a: assert property (@(posedge clk) disable iff (!nrst) // see R3
      s_match[0] |=> ((vin_laddr ^ $past(vin_addr))
                      & ~$past(slv_mask[0])) == 32'h0000_0000)
      else $error("non-significant bit altered");
   sio_a16_a: assert property (@(posedge clk) disable iff (!nrst) // see R8
      sio_match |=> vout_a16 && vout_start && vout_ctl == $past(sio_ctl))
      else $error("short io cycle wrong");
   fpg_a24_a: assert property (@(posedge clk) disable iff (!nrst) // see R9
      fpg_match && !sio_match |=> vout_a24 && vout_addr[31:24] == 8'h00)
      else $error("top page cycle wrong");
   // Both group and board values must match the decoded address
   ctl_block_a: assert property (@(posedge clk) disable iff (!nrst) // see R10
      ctl_block_hit |-> $past(lb_addr[15:0])
         == {$past(group_select_value), $past(board_select_value)})
      else $error("control block decode wrong");
   mst_low_a: assert property (@(posedge clk) disable iff (!nrst) // see R5
      m_match[0] && !sio_match && !fpg_match |=> vout_addr == $past(lb_addr))
      else $error("untranslated master changed address");
endmodule : vwd_top

// [hw/vwd_pkg.sv]
// Purpose: Constants and types for the bus window decoders
// Assumes: 100 MHz clock, 32-bit local and bus addresses
// Notes:   How it works list below
//
// How it works
// R1: Slave window claims bus address in range
// R2: Slave window translates onto local base
// R3: Select mask bit one means significant bit
// R4: Slave control restricts accepted access kinds
// R5: Four master windows, only fourth translates
// R6: Fourth master substitutes translation under mask
// R7: Master control sets generated cycle attributes
// R8: Short I/O window maps onto A16 space
// R9: Top page window maps onto A24 space
// R10: Control block placed by group, board values
// R11: System controller bus timeout, code 01 64us
// R12: Unanswered local cycle timeout, code 02 256us
// R13: Bus access wait timeout, code 02 32ms
// R14: Slave window needs its own enable
// R15: No enabled match means no bus cycle
package vwd_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ      = 100;         // Clock rate
   localparam int TICK_US      = 1;           // Timer tick, one microsecond
   localparam int TICK_CYC     = TICK_US * CLK_MHZ;
   localparam int TICK_W       = 7;           // Width of tick divider
   // Timeout figures per code, bus and local in microseconds, access in ms
   localparam int BUS_TO_US1   = 64;
   localparam int LOC_TO_US2   = 256;
   localparam int ACC_TO_MS2   = 32;
   localparam int TO_W         = 16;          // Width of timeout counters
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [1:0] BUS_TO_RST = 2'h1;
   localparam logic [1:0] LOC_TO_RST = 2'h2;
   localparam logic [1:0] ACC_TO_RST = 2'h2;
   localparam logic [7:0] GRP_RST    = 8'hD2;
   localparam logic [7:0] BRD_RST    = 8'h00;
   // Short I/O and top page local windows
   localparam logic [15:0] SIO_BASE  = 16'hFFFF;
   localparam logic [7:0]  FPG_BASE  = 8'hFF;
   // Timer state
   typedef enum logic [1:0] {
      VWD_IDLE = 2'b00,
      VWD_WAIT = 2'b01,
      VWD_DONE = 2'b10
   } vwd_tmr_t;
endpackage : vwd_pkg

// [hw/vwd_timer.sv]
// Purpose: Coded timeout in microsecond ticks
// Assumes: tick is a one-cycle pulse each microsecond
// Notes:   Expires once per run; run low clears it
`timescale 1ns/10ps
module vwd_timer
   import vwd_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            nrst,
   // Control
   input  wire logic            tick,
   input  wire logic            run,
   input  wire logic [TO_W-1:0] limit,
   // Result
   output logic                 expired
);
   logic [TO_W-1:0] cnt;      // Ticks elapsed
   logic [TO_W-1:0] next_cnt;
   vwd_tmr_t        st;       // Timer state
   vwd_tmr_t        next_st;
   // Next state
   always_comb begin
      next_cnt = cnt;
      next_st  = st;
      case (st)
         VWD_IDLE: begin
            next_cnt = '0;
            if (run) next_st = VWD_WAIT;
         end
         VWD_WAIT: begin
            if (!run) next_st = VWD_IDLE;
            else if (tick) begin
               next_cnt = cnt + 1'b1;
               if (cnt + 1'b1 >= limit) next_st = VWD_DONE;
            end
         end
         VWD_DONE: if (!run) next_st = VWD_IDLE;
         default:  next_st = VWD_IDLE;
      endcase
   end
   // Registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt <= '0;
         st  <= VWD_IDLE;
      end else begin
         cnt <= next_cnt;
         st  <= next_st;
      end
   end
   assign expired = (st == VWD_DONE);
endmodule : vwd_timer

// [dv/vwd_far_end.sv]
// Purpose: Model of the far-side bus agents for the window decoders
// Assumes: Bench asks for incoming accesses one cycle at a time
// Notes:   Slow mode never answers, so the timeout timers can run
`timescale 1ns/10ps
module vwd_far_end (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Commands from the bench
   input  wire logic        cmd_valid,
   input  wire logic [31:0] cmd_addr,
   input  wire logic [15:0] cmd_kind,
   input  wire logic        slow,
   // Outgoing cycle seen from the block
   input  wire logic        vout_start,
   // Incoming access and answers
   output logic             vin_valid,
   output logic [31:0]      vin_addr,
   output logic [15:0]      vin_kind,
   output logic             lb_ack,
   output logic             bus_grant,
   output logic             bus_busy
);
   // ****************************************
   // Answer state
   // ****************************************
   logic [31:0] last_addr;    // Last address put on the lines
   logic        ack_d;        // Answer one cycle after a started cycle
   // Registered answer; slow mode swallows it
   always_ff @(posedge clk) begin
      if (!nrst) begin
         last_addr <= 32'h0000_0000;
         ack_d     <= 1'b0;
      end else begin
         if (cmd_valid) begin
            last_addr <= cmd_addr;
         end
         ack_d <= vout_start & ~slow;
      end
   end
   // Released lines show the inverse, so stale values never match
   assign vin_valid = cmd_valid;
   assign vin_addr  = cmd_valid ? cmd_addr : ~last_addr;
   assign vin_kind  = cmd_valid ? cmd_kind : 16'h0000;
   assign lb_ack    = ack_d;
   assign bus_grant = ~slow;
   assign bus_busy  = slow | ack_d;
endmodule : vwd_far_end

// [dv/vwd_top_bench.sv]
// Purpose: Self-checking bench for the window decoders
// Assumes: Far side modelled by vwd_far_end
// Notes:   Table rows first, then timers and a mid-run reset
`timescale 1ns/10ps
module vwd_top_bench;
   import vwd_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   typedef struct packed {
      logic [31:0] a; logic st; logic [31:0] va; logic [7:0] c;
      logic a16; logic a24; logic g;
   } vwd_mrow_t;              // Local address row
   typedef struct packed {
      logic [1:0] en; logic [31:0] a; logic [15:0] k;
      logic h; logic [1:0] s; logic [31:0] la;
   } vwd_srow_t;              // Incoming access row
   logic clk = 0, nrst = 0, sio_en, fpg_en, lb_valid, sys_ctl, slow;
   logic cmd_valid, vin_valid, vin_hit, lb_ack, bus_grant, bus_busy;
   logic vout_start, vout_a16, vout_a24, ctl_block_hit;
   logic bus_to, loc_to, acc_to;
   logic [1:0]  slv_en, vin_sel, bus_code, loc_code, acc_code;
   logic [3:0]  mst_en;
   logic [7:0]  mst_ctl [4];
   logic [7:0]  sio_ctl, fpg_ctl, grp, brd, vout_ctl;
   logic [15:0] slv_ctl [2];
   logic [15:0] cmd_kind, vin_kind;
   logic [31:0] slv_start [2], slv_end [2], slv_xlat [2], slv_mask [2];
   logic [31:0] mst_start [4], mst_end [4], mst_xlat, mst_mask;
   logic [31:0] lb_addr, cmd_addr, vin_addr, vin_laddr, vout_addr;
   int err_count = 0, compares = 0;
   localparam vwd_mrow_t MR [10] = '{
      '{32'h0200_0000, 1, 32'h0200_0000, 8'h0D, 0, 0, 0},
      '{32'h0FFF_FFFF, 1, 32'h0FFF_FFFF, 8'h0D, 0, 0, 0},
      '{32'h1000_0004, 0, 32'h0, 8'h0, 0, 0, 0},
      '{32'h00FF_FFFC, 1, 32'h00FF_FFFC, 8'h3D, 0, 0, 0},
      '{32'h2012_3456, 1, 32'h5A12_3456, 8'h44, 0, 0, 0},
      '{32'hFFFF_1234, 1, 32'h0000_1234, 8'h01, 1, 0, 0},
      '{32'hFF12_3456, 1, 32'h0012_3456, 8'h02, 0, 1, 0},
      '{32'h3000_0000, 0, 32'h0, 8'h0, 0, 0, 0},
      '{32'hFFFF_D200, 1, 32'h0000_D200, 8'h01, 1, 0, 1},
      '{32'hFFFF_D300, 1, 32'h0000_D300, 8'h01, 1, 0, 0}};
   localparam vwd_srow_t SR [8] = '{
      '{2'h3, 32'h0001_2340, 16'h0001, 1, 2'h1, 32'h0041_2340},
      '{2'h3, 32'h000F_FFFF, 16'h0200, 1, 2'h1, 32'h004F_FFFF},
      '{2'h3, 32'h0001_0000, 16'h0400, 0, 2'h0, 32'h0},
      '{2'h3, 32'h0123_4560, 16'h0004, 1, 2'h2, 32'h0823_4560},
      '{2'h3, 32'h0123_4560, 16'h0001, 0, 2'h0, 32'h0},
      '{2'h3, 32'h0200_0000, 16'h0001, 0, 2'h0, 32'h0},
      '{2'h2, 32'h0001_2340, 16'h0001, 0, 2'h0, 32'h0},
      '{2'h1, 32'h0123_4560, 16'h0004, 0, 2'h0, 32'h0}};
   // ****************************************
   // Instances
   // ****************************************
   vwd_top vwd_top_inst (.clk(clk), .nrst(nrst), .slv_en(slv_en),
      .slv_start(slv_start), .slv_end(slv_end), .slv_xlat(slv_xlat),
      .slv_mask(slv_mask), .slv_ctl(slv_ctl), .vin_valid(vin_valid),
      .vin_addr(vin_addr), .vin_kind(vin_kind), .vin_hit(vin_hit),
      .vin_sel(vin_sel), .vin_laddr(vin_laddr), .mst_en(mst_en),
      .mst_start(mst_start), .mst_end(mst_end), .mst_xlat(mst_xlat),
      .mst_mask(mst_mask), .mst_ctl(mst_ctl), .sio_en(sio_en),
      .sio_ctl(sio_ctl), .fpg_en(fpg_en), .fpg_ctl(fpg_ctl),
      .group_select_value(grp), .board_select_value(brd),
      .lb_valid(lb_valid), .lb_addr(lb_addr), .lb_ack(lb_ack),
      .bus_grant(bus_grant), .sys_ctl(sys_ctl), .bus_busy(bus_busy),
      .vout_start(vout_start), .vout_addr(vout_addr),
      .vout_ctl(vout_ctl), .vout_a16(vout_a16), .vout_a24(vout_a24),
      .ctl_block_hit(ctl_block_hit), .bus_to_code(bus_code),
      .loc_to_code(loc_code), .acc_to_code(acc_code),
      .bus_timeout(bus_to), .loc_timeout(loc_to), .acc_timeout(acc_to));
   vwd_far_end vwd_far_end_inst (.clk(clk), .nrst(nrst),
      .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_kind(cmd_kind),
      .slow(slow), .vout_start(vout_start), .vin_valid(vin_valid),
      .vin_addr(vin_addr), .vin_kind(vin_kind), .lb_ack(lb_ack),
      .bus_grant(bus_grant), .bus_busy(bus_busy));
   // 100 MHz clock
   always #5 clk = ~clk;
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask : check
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // Hang guard, well past the local timeout, the longest timer tested
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      slv_start = '{32'h0, 32'h0100_0000};
      slv_end   = '{32'h000F_FFFF, 32'h01FF_FFFF};
      slv_xlat  = '{32'h0040_0000, 32'h0800_0000};
      slv_mask  = '{32'hFFF0_0000, 32'hFF00_0000};
      slv_ctl   = '{16'h03FF, 16'h0004};
      mst_start = '{32'h0200_0000, 32'h1000_0000, 32'h0, 32'h2000_0000};
      mst_end   = '{32'h0FFF_FFFF, 32'h1FFF_FFFF, 32'h00FF_FFFF,
                    32'h2FFF_FFFF};
      mst_ctl   = '{8'h0D, 8'h00, 8'h3D, 8'h44};
      mst_en = 4'hD; mst_xlat = 32'h5A00_0000; mst_mask = 32'hFF00_0000;
      sio_en = 1; sio_ctl = 8'h01; fpg_en = 1; fpg_ctl = 8'h02;
      grp = GRP_RST; brd = BRD_RST; slv_en = 2'h3; lb_valid = 0;
      lb_addr = 0; sys_ctl = 0; slow = 0; cmd_valid = 0; cmd_addr = 0;
      cmd_kind = 0; bus_code = BUS_TO_RST; loc_code = LOC_TO_RST;
      acc_code = ACC_TO_RST;
      repeat (12) @(negedge clk);
      check(vout_start | vin_hit | loc_to, 0, "reset outputs");
      check({vout_a16, vout_a24, ctl_block_hit, bus_to, acc_to}, 0,
            "reset flags");
      nrst = 1;
      // Local windows, one request each; valid held up between rows
      foreach (MR[i]) begin
         lb_valid = 1; lb_addr = MR[i].a;
         @(negedge clk);
         check(vout_start, MR[i].st, "start");
         check(ctl_block_hit, MR[i].g, "control block hit");
         if (MR[i].st) begin
            check(vout_addr, MR[i].va, "bus address");
            check(vout_ctl, MR[i].c, "cycle control");
            check({vout_a16, vout_a24}, {MR[i].a16, MR[i].a24},
                  "space");
         end
      end
      // Disabled short I/O and top page windows claim nothing
      sio_en = 0; fpg_en = 0; lb_addr = 32'hFFFF_D200;
      @(negedge clk);
      check(vout_start | ctl_block_hit, 0, "short io off");
      lb_addr = 32'hFF12_3456;
      @(negedge clk);
      check(vout_start, 0, "top page off");
      lb_valid = 0; sio_en = 1; fpg_en = 1;
      $display("test local windows done");
      // Incoming accesses, one per cycle; valid held up between rows
      foreach (SR[i]) begin
         slv_en = SR[i].en; cmd_valid = 1;
         cmd_addr = SR[i].a; cmd_kind = SR[i].k;
         @(negedge clk);
         check(vin_hit, SR[i].h, "slave hit");
         check(vin_sel, SR[i].s, "slave select");
         if (SR[i].h) begin
            check(vin_laddr, SR[i].la, "local address");
         end
      end
      cmd_valid = 0;
      $display("test slave windows done");
      // Unanswered cycle with the bus held busy
      slow = 1; sys_ctl = 1; lb_valid = 1; lb_addr = 32'h0200_0000;
      repeat (6300) @(negedge clk);
      check(bus_to | loc_to, 0, "early timeout");
      repeat (400) @(negedge clk);
      check(bus_to, 1, "bus timeout 64us");
      check(loc_to | acc_to, 0, "early local timeout");
      repeat (18700) @(negedge clk);
      check(loc_to, 0, "local timeout early");
      repeat (700) @(negedge clk);
      check(loc_to, 1, "local timeout 256us");
      // Reset in mid-run clears the timers
      nrst = 0;
      @(negedge clk);
      check(loc_to | bus_to | vout_start, 0, "mid-run reset");
      // Request still held is taken at the first edge after release
      nrst = 1; slow = 0;
      @(negedge clk);
      check(vout_start, 1, "request after reset");
      check(vout_addr, 32'h0200_0000, "address after reset");
      lb_valid = 0; sys_ctl = 0;
      @(negedge clk);
      check(vout_start | bus_to | loc_to, 0, "idle after reset");
      $display("test timers done");
      give_verdict();
   end
endmodule : vwd_top_bench
